/* File: design/cpsu_defs.svh */
// constants for the code privilege and stack unit
`ifndef CPSU_DEFS_SVH
`define CPSU_DEFS_SVH
`define CPSU_STACK_TOP 16'h0bf0
`define CPSU_UROM_BASE 16'h8000
`define CPSU_UROM_WORDS 16'h0c00
`define CPSU_PAGE_SHIFT 8
`define CPSU_PAGE_W 8
`endif

/* File: design/cpsu_pkg.sv */
// types shared by the code privilege and stack unit
package cpsu_pkg;
  typedef enum logic [2:0] {
    stack_none = 3'h0,
    subroutine_enter_op = 3'h1,
    stack_store_op = 3'h2,
    interrupt_vector_op = 3'h3,
    subroutine_exit_op = 3'h4,
    interrupt_exit_op = 3'h5,
    stack_load_op = 3'h6,
    stack_load_variant_op = 3'h7
  } stack_op_e;

  typedef enum logic [1:0] {
    priv_low = 2'h0,
    priv_med = 2'h1,
    priv_high = 2'h2
  } priv_e;

  typedef enum logic [0:0] {
    space_code = 1'h0,
    space_data = 1'h1
  } space_e;

  typedef struct packed {
    stack_op_e op;
    logic [15:0] data;
  } stack_req_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    space_e space;
    logic [15:0] addr;
  } mem_req_s;
endpackage

/* File: design/code_privilege_and_stack_unit.sv */
// stack pointer, stack storage and code privilege checking for the core
//
// Functional notes
// - reset loads stack pointer with 0bf0h
// - store ops decrement pointer, then write
// - load ops read at pointer, then increment
// - sixteen-bit entries; calls and interrupts use stack
// - software stores and loads general data explicitly
// - protection splits code into three ascending areas
// - system high, loader medium, application low privilege
// - utility rom high, ram low privilege
// - user code may be barred from system code
// - loader area optionally guarded from application code
// - utility rom is 6KB starting 8000h
// - 16-bit buses; data as bytes or words
`timescale 1ns/100ps
`include "cpsu_defs.svh"

module code_privilege_and_stack_unit
  import cpsu_pkg::*;
#(
  parameter int STACK_DEPTH = 16,
  parameter logic [15:0] UROM_BASE = `CPSU_UROM_BASE
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire stack_req_s stack_req_in,
  input wire logic protect_enable_in,
  input wire logic system_guard_in,
  input wire logic loader_guard_in,
  input wire logic urom_mapped_in,
  input wire logic [`CPSU_PAGE_W-1:0] loader_area_start_in,
  input wire logic [`CPSU_PAGE_W-1:0] application_area_start_in,
  input wire logic [15:0] exec_addr_in,
  input wire space_e exec_space_in,
  input wire mem_req_s mem_req_in,
  output logic [15:0] stack_top_pointer_out,
  output logic [15:0] pop_data_out,
  output logic pop_valid_out,
  output logic stack_fault_out,
  output priv_e cur_priv_out,
  output logic access_grant_out,
  output logic access_deny_out
);

  localparam int IW = $clog2(STACK_DEPTH);
  localparam logic [15:0] STACK_LOW = 16'(`CPSU_STACK_TOP - STACK_DEPTH);

  //////////////////////////////////////////////////////////////////////////////
  // privilege decode, shared by the executing and the target address

  function automatic priv_e area_priv(input space_e sp, input logic [15:0] a,
                                      input logic rom_on,
                                      input logic [`CPSU_PAGE_W-1:0] ldr,
                                      input logic [`CPSU_PAGE_W-1:0] app);
    logic [`CPSU_PAGE_W-1:0] page;
    page = a[`CPSU_PAGE_SHIFT +: `CPSU_PAGE_W];
    if (sp == space_data) begin
      area_priv = priv_low;
    end else if (rom_on && a >= UROM_BASE && a < 16'(UROM_BASE + `CPSU_UROM_WORDS)) begin
      area_priv = priv_high;
    end else if (page < ldr) begin
      area_priv = priv_high;
    end else if (page < app) begin
      area_priv = priv_med;
    end else begin
      area_priv = priv_low;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // stack pointer and storage

  // storage index is the low pointer bits; the depth must keep the stack
  // window aligned below the top so that the index never wraps mid-stack
  logic [15:0] stack_top_pointer;
  logic [15:0] next_stack_top_pointer;
  logic [15:0] stack_mem [STACK_DEPTH];
  logic [15:0] next_stack_mem [STACK_DEPTH];
  logic [15:0] next_pop_data;
  logic next_pop_valid;
  logic next_stack_fault;
  logic is_store;
  logic is_load;
  logic [15:0] dec_ptr;

  assign is_store = stack_req_in.op inside {subroutine_enter_op, stack_store_op,
                                            interrupt_vector_op};
  assign is_load = stack_req_in.op inside {subroutine_exit_op, interrupt_exit_op,
                                           stack_load_op, stack_load_variant_op};
  assign dec_ptr = 16'(stack_top_pointer - 16'h0001);

  always_comb begin
    next_stack_top_pointer = stack_top_pointer;
    next_stack_mem = stack_mem;
    next_pop_data = pop_data_out;
    next_pop_valid = 1'b0;
    next_stack_fault = 1'b0;
    if (is_store) begin
      if (stack_top_pointer == STACK_LOW) begin
        next_stack_fault = 1'b1;
      end else begin
        next_stack_top_pointer = dec_ptr;
        next_stack_mem[dec_ptr[IW-1:0]] = stack_req_in.data;
      end
    end else if (is_load) begin
      if (stack_top_pointer == `CPSU_STACK_TOP) begin
        next_stack_fault = 1'b1;
      end else begin
        next_pop_data = stack_mem[stack_top_pointer[IW-1:0]];
        next_pop_valid = 1'b1;
        next_stack_top_pointer = 16'(stack_top_pointer + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stack_top_pointer <= `CPSU_STACK_TOP;
      pop_data_out <= 16'h0000;
      pop_valid_out <= 1'b0;
      stack_fault_out <= 1'b0;
    end else begin
      stack_top_pointer <= next_stack_top_pointer;
      pop_data_out <= next_pop_data;
      pop_valid_out <= next_pop_valid;
      stack_fault_out <= next_stack_fault;
    end
  end

  // entries carry no reset; a load is only valid after a matching store
  always_ff @(posedge clk_in) begin
    stack_mem <= next_stack_mem;
  end

  assign stack_top_pointer_out = stack_top_pointer;

  //////////////////////////////////////////////////////////////////////////////
  // access check

  priv_e cur_priv;
  priv_e tgt_priv;
  logic guarded;
  logic misaligned;
  logic next_grant;
  logic next_deny;
  priv_e next_cur_priv;

  always_comb begin
    cur_priv = area_priv(exec_space_in, exec_addr_in, urom_mapped_in,
                         loader_area_start_in, application_area_start_in);
    tgt_priv = area_priv(mem_req_in.space, mem_req_in.addr, urom_mapped_in,
                         loader_area_start_in, application_area_start_in);
    // the two documented guards and a misaligned data word can refuse; rom follows the system guard
    guarded = (tgt_priv == priv_high && system_guard_in)
              || (tgt_priv == priv_med && loader_guard_in);
    // data words live on even byte addresses of the data bus
    misaligned = mem_req_in.space == space_data && mem_req_in.word
                 && mem_req_in.addr[0];
    next_deny = mem_req_in.valid && (misaligned || (protect_enable_in
                && tgt_priv > cur_priv && guarded));
    next_grant = mem_req_in.valid && !next_deny;
    next_cur_priv = protect_enable_in ? cur_priv : priv_high;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      access_grant_out <= 1'b0;
      access_deny_out <= 1'b0;
      cur_priv_out <= priv_high;
    end else begin
      access_grant_out <= next_grant;
      access_deny_out <= next_deny;
      cur_priv_out <= next_cur_priv;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks

  logic [`CPSU_PAGE_W-1:0] exec_page;
  logic exec_in_rom;

  assign exec_page = exec_addr_in[`CPSU_PAGE_SHIFT +: `CPSU_PAGE_W];
  assign exec_in_rom = urom_mapped_in && exec_addr_in >= UROM_BASE
                       && exec_addr_in < 16'(UROM_BASE + `CPSU_UROM_WORDS);

  sequence s_store_req;
    is_store && stack_top_pointer != STACK_LOW;
  endsequence

  sequence s_load_req;
    is_load && stack_top_pointer != `CPSU_STACK_TOP;
  endsequence

  // a store taken and the load right behind it must hand the same word back
  sequence s_push_then_pop;
    s_store_req ##1 s_load_req;
  endsequence

  a_reset_top_ptr: assert property (@(posedge clk_in)
    !reset_n_in |=> stack_top_pointer_out == `CPSU_STACK_TOP)
    else $error("pointer not at stack top after reset");

  a_store_dec: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_store_req |=> stack_top_pointer_out == 16'($past(stack_top_pointer_out) - 16'h0001))
    else $error("store did not decrement pointer");

  a_load_inc: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_load_req |=> stack_top_pointer_out == 16'($past(stack_top_pointer_out) + 16'h0001)
    && pop_valid_out)
    else $error("load did not increment pointer");

  a_store_load_trip: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    s_push_then_pop |=> pop_data_out == $past(stack_req_in.data, 2))
    else $error("loaded value differs from stored value");

  a_explicit_data: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (stack_req_in.op == stack_store_op && stack_top_pointer != STACK_LOW)
    |=> stack_mem[stack_top_pointer[IW-1:0]] == $past(stack_req_in.data))
    else $error("explicit store lost its data");

  a_prot_off_grant: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mem_req_in.valid && !protect_enable_in && !misaligned) |=> access_grant_out)
    else $error("access refused with protection off");

  a_ram_low_priv: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (protect_enable_in && exec_space_in == space_data) |=> cur_priv_out == priv_low)
    else $error("ram code not at low privilege");

  a_system_guard: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mem_req_in.valid && protect_enable_in && system_guard_in && tgt_priv == priv_high
     && cur_priv != priv_high) |=> access_deny_out && !access_grant_out)
    else $error("user code reached system area");

  a_loader_guard: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mem_req_in.valid && protect_enable_in && loader_guard_in && tgt_priv == priv_med
     && cur_priv == priv_low) |=> access_deny_out)
    else $error("application code reached loader area");

  a_rom_window: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (urom_mapped_in && protect_enable_in && exec_space_in == space_code
     && exec_addr_in >= UROM_BASE && exec_addr_in < 16'(UROM_BASE + `CPSU_UROM_WORDS))
    |=> cur_priv_out == priv_high)
    else $error("utility rom code not at high privilege");

  a_full_refused: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_store && stack_top_pointer == STACK_LOW)
    |=> stack_fault_out && $stable(stack_top_pointer_out))
    else $error("store on a full stack not refused");

  a_empty_refused: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (is_load && stack_top_pointer == `CPSU_STACK_TOP)
    |=> stack_fault_out && !pop_valid_out && $stable(stack_top_pointer_out))
    else $error("load on an empty stack not refused");

  a_idle_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (!is_store && !is_load)
    |=> !stack_fault_out && !pop_valid_out && $stable(stack_top_pointer_out))
    else $error("idle cycle moved the stack");

  a_pointer_window: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    stack_top_pointer_out <= `CPSU_STACK_TOP && stack_top_pointer_out >= STACK_LOW)
    else $error("pointer left the stack window");

  // a reset edge clears the held word, so the cycle after it is exempt
  a_pop_data_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    ($past(reset_n_in) && !pop_valid_out) |-> $stable(pop_data_out))
    else $error("pop data changed without a load");

  a_protect_off_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !protect_enable_in |=> cur_priv_out == priv_high)
    else $error("privilege not high with protection off");

  a_system_area_high: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (protect_enable_in && exec_space_in == space_code && !exec_in_rom
     && exec_page < loader_area_start_in) |=> cur_priv_out == priv_high)
    else $error("system area code not at high privilege");

  a_loader_area_med: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (protect_enable_in && exec_space_in == space_code && !exec_in_rom
     && exec_page >= loader_area_start_in && exec_page < application_area_start_in)
    |=> cur_priv_out == priv_med)
    else $error("loader area code not at medium privilege");

  a_app_area_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (protect_enable_in && exec_space_in == space_code && !exec_in_rom
     && exec_page >= loader_area_start_in && exec_page >= application_area_start_in)
    |=> cur_priv_out == priv_low)
    else $error("application area code not at low privilege");

  a_misaligned_deny: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mem_req_in.valid && mem_req_in.space == space_data && mem_req_in.word
     && mem_req_in.addr[0]) |=> access_deny_out)
    else $error("odd data word access not denied");

  a_lower_grant: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    (mem_req_in.valid && !misaligned && tgt_priv <= cur_priv) |=> access_grant_out)
    else $error("access to an equal or lower area refused");

  a_grant_deny_excl: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !(access_grant_out && access_deny_out))
    else $error("grant and deny raised together");

  a_access_answer: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    mem_req_in.valid |=> access_grant_out != access_deny_out)
    else $error("request did not get exactly one answer");

  a_access_idle: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    !mem_req_in.valid |=> !access_grant_out && !access_deny_out)
    else $error("answer raised without a request");

endmodule

/* File: verification/core_model.sv */
// core-side model: issues one-cycle memory requests and stack operations
`timescale 1ns/100ps

module core_model
  import cpsu_pkg::*;
(
  input wire logic clk_in,
  input wire logic issue_in,
  input wire mem_req_s mem_in,
  input wire stack_req_s stack_in,
  output mem_req_s mem_req_out,
  output stack_req_s stack_req_out
);
  initial begin
    mem_req_out = '0;
    stack_req_out = '0;
  end

  // an idle bus does not keep its last address or data, so idle cycles show their inverse
  always @(posedge clk_in) begin
    if (issue_in) begin
      mem_req_out <= '{valid: 1'b1, write: mem_in.write, word: mem_in.word,
                       space: mem_in.space, addr: mem_in.addr};
    end else begin
      mem_req_out <= '{valid: 1'b0, write: mem_req_out.write, word: mem_req_out.word,
                       space: mem_req_out.space, addr: ~mem_req_out.addr};
    end
    if (stack_in.op != stack_none) begin
      stack_req_out <= stack_in;
    end else begin
      stack_req_out <= '{op: stack_none, data: ~stack_req_out.data};
    end
  end
endmodule

/* File: verification/tb.sv */
// self-checking bench for the code privilege and stack unit
`timescale 1ns/100ps

module tb;
  import cpsu_pkg::*;
  typedef struct packed {
    logic [15:0] ex;
    logic [3:0] cfg;
    logic [15:0] ta;
    space_e sp;
    logic wd;
    priv_e pr;
    logic gr;
  } row_s;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic issue = 1'b0;
  logic [3:0] cfg = 4'h0;
  logic [15:0] exec_addr = 16'h0000;
  space_e exec_space = space_code;
  logic [7:0] loader_start = 8'h10;
  logic [7:0] app_start = 8'h40;
  mem_req_s mem_in = '0;
  stack_req_s stack_in = '0;
  mem_req_s mem_req;
  stack_req_s stack_req;
  logic [15:0] sp_out;
  logic [15:0] pop_data;
  logic pop_valid, fault, grant, deny;
  priv_e cur_priv;
  int errors = 0;
  int check_count = 0;
  // cfg is {protect, system guard, loader guard, rom mapped}; loader page 10h, app page 40h
  row_s rows [15] = '{
    '{16'h0100, 4'hf, 16'h4500, space_code, 1'b1, priv_high, 1'b1},
    '{16'h0fff, 4'hf, 16'h1000, space_code, 1'b1, priv_high, 1'b1},
    '{16'h1000, 4'hf, 16'h0fff, space_code, 1'b1, priv_med, 1'b0},
    '{16'h3fff, 4'hf, 16'h4000, space_code, 1'b1, priv_med, 1'b1},
    '{16'h4000, 4'hf, 16'h3fff, space_code, 1'b1, priv_low, 1'b0},
    '{16'h4000, 4'hd, 16'h3fff, space_code, 1'b1, priv_low, 1'b1},
    '{16'h4000, 4'hb, 16'h0000, space_code, 1'b1, priv_low, 1'b1},
    '{16'h4000, 4'hf, 16'h0000, space_code, 1'b1, priv_low, 1'b0},
    '{16'h4000, 4'hf, 16'h8bff, space_code, 1'b1, priv_low, 1'b0},
    '{16'h4000, 4'hf, 16'h8c00, space_code, 1'b1, priv_low, 1'b1},
    '{16'h4000, 4'he, 16'h8000, space_code, 1'b1, priv_low, 1'b1},
    '{16'h4000, 4'hf, 16'h0200, space_data, 1'b1, priv_low, 1'b1},
    '{16'h4000, 4'hf, 16'h0201, space_data, 1'b1, priv_low, 1'b0},
    '{16'h4000, 4'hf, 16'h0201, space_data, 1'b0, priv_low, 1'b1},
    '{16'h4000, 4'h7, 16'h0000, space_code, 1'b1, priv_high, 1'b1}
  };

  always #2.5 clk_in = ~clk_in;

  core_model core (.clk_in(clk_in), .issue_in(issue), .mem_in(mem_in), .stack_in(stack_in),
    .mem_req_out(mem_req), .stack_req_out(stack_req));

  code_privilege_and_stack_unit #(.STACK_DEPTH(16)) dut (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .stack_req_in(stack_req), .protect_enable_in(cfg[3]),
    .system_guard_in(cfg[2]), .loader_guard_in(cfg[1]), .urom_mapped_in(cfg[0]),
    .loader_area_start_in(loader_start), .application_area_start_in(app_start),
    .exec_addr_in(exec_addr), .exec_space_in(exec_space), .mem_req_in(mem_req),
    .stack_top_pointer_out(sp_out), .pop_data_out(pop_data), .pop_valid_out(pop_valid),
    .stack_fault_out(fault), .cur_priv_out(cur_priv), .access_grant_out(grant),
    .access_deny_out(deny));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (!ok) begin
      errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // the model adds one cycle, so an answer lands two edges after it is driven
  task automatic acc(input row_s r, input logic wr);
    @(posedge clk_in);
    cfg <= r.cfg;
    exec_addr <= r.ex;
    issue <= 1'b1;
    mem_in <= '{1'b1, wr, r.wd, r.sp, r.ta};
    @(posedge clk_in);
    issue <= 1'b0;
    @(posedge clk_in);
    #1;
    chk(grant === r.gr && deny === !r.gr && cur_priv === r.pr, "access result");
    @(posedge clk_in);
    #1;
    chk(grant === 1'b0 && deny === 1'b0, "access pulse length");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(4000 * 5);
    errors++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk_in);
    reset_n_in <= 1'b1;
    #1;
    chk(sp_out === 16'h0bf0 && cur_priv === priv_high, "reset state");
    foreach (rows[i]) acc(rows[i], i[0]);
    // ram code and moved area bounds are not reachable from the table
    @(posedge clk_in);
    exec_space <= space_data;
    acc(row_s'{16'h0100, 4'hf, 16'h0000, space_code, 1'b1, priv_low, 1'b0}, 1'b0);
    @(posedge clk_in);
    exec_space <= space_code;
    loader_start <= 8'h02;
    app_start <= 8'h03;
    acc(row_s'{16'h0250, 4'hf, 16'h0100, space_code, 1'b1, priv_med, 1'b0}, 1'b1);
    acc(row_s'{16'h0300, 4'hf, 16'h02ff, space_code, 1'b1, priv_low, 1'b0}, 1'b0);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (i < 17) stack_in <= '{stack_op_e'(1 + i % 3), 16'(16'ha000 + i)};
      else stack_in <= '0;
      #1;
      if (i == 2) chk(sp_out === 16'h0bef, "push pointer");
      if (i == 17) chk(fault === 1'b0 && sp_out === 16'h0be0, "stack depth");
      if (i == 18) chk(fault === 1'b1 && sp_out === 16'h0be0, "full stack");
    end
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_in);
      if (i < 17) stack_in <= '{stack_op_e'(4 + i % 4), 16'h0000};
      else stack_in <= '0;
      #1;
      if (i >= 2 && i <= 17)
        chk(pop_valid === 1'b1 && pop_data === 16'(16'ha011 - i), "pop order");
      if (i == 2) chk(sp_out === 16'h0be1, "pop pointer");
      if (i == 18) chk(fault === 1'b1 && sp_out === 16'h0bf0, "empty stack");
    end
    @(posedge clk_in);
    stack_in <= '{stack_store_op, 16'h1234};
    @(posedge clk_in);
    stack_in <= '{subroutine_exit_op, 16'h0000};
    @(posedge clk_in);
    stack_in <= '{subroutine_enter_op, 16'h5678};
    @(posedge clk_in);
    stack_in <= '0;
    #1;
    chk({pop_valid, pop_data, sp_out} === {1'b1, 16'h1234, 16'h0bf0}, "push pop");
    @(posedge clk_in);
    #1;
    chk(sp_out === 16'h0bef, "second push");
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk({sp_out, pop_valid, pop_data} === {16'h0bf0, 1'b0, 16'h0000}, "reset mid run");
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    stack_in <= '{stack_store_op, 16'h9abc};
    @(posedge clk_in);
    stack_in <= '0;
    @(posedge clk_in);
    #1;
    chk(sp_out === 16'h0bef && fault === 1'b0, "push after reset");
    close_out();
  end
endmodule
